// >>> core/hp_params.svh
/*
 Constants of the host port pin front end: widths, depths and fixed levels.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef HP_PARAMS_SVH
`define HP_PARAMS_SVH

`define HP_DATA_W      16
`define HP_BYTE_W      8
`define HP_ADDR_W      4
`define HP_SYS_W       32
`define HP_FIFO_DEPTH  4
`define HP_FIFO_W      20
`define HP_SYNC_W      6
`define HP_SYNC_STAGES 2
`define HP_SYN_SEL_A   0
`define HP_SYN_SEL_B   1
`define HP_SYN_DIR     2
`define HP_SYN_RD      3
`define HP_SYN_WR      4
`define HP_SYN_DS      5
`define HP_ZERO16      16'h0000
`define HP_ZERO8       8'h00
`define HP_ZERO4       4'h0
`define HP_ZERO32      32'h0000_0000
`define HP_OE_ALL      16'hffff
`define HP_OE_BYTE     16'h00ff

`endif

// >>> core/hp_pkg.sv
/*
 Types shared by the host port front end: access state and write word layout.
 Assumes hp_params.svh is reachable on the include path.
*/
`default_nettype none
`include "hp_params.svh"

package hp_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD_FETCH,
      ST_RD_DRIVE,
      ST_WR_PUSH,
      ST_WAIT_END
   } acc_state_t;

   typedef struct packed {
      logic [`HP_ADDR_W-1:0] addr;
      logic [`HP_DATA_W-1:0] data;
   } wr_word_t;

endpackage

`default_nettype wire

// >>> core/hp_fifo_if.sv
/*
 Interface joining the front end to its write FIFO: fill side and drain side.
 Assumes one clock; valid and ready follow the usual handshake on each side.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hp_params.svh"

interface hp_fifo_if;
   logic                  in_valid;
   logic                  in_ready;
   logic [`HP_FIFO_W-1:0] in_data;
   logic                  out_valid;
   logic                  out_ready;
   logic [`HP_FIFO_W-1:0] out_data;

   modport src  (output in_valid, output in_data, input in_ready,
                 input out_valid, input out_data, output out_ready);
   modport fifo (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
endinterface

`default_nettype wire

// >>> core/hp_sync.sv
/*
 Two-flop synchronisers, one per bit, for asynchronous host pin levels.
 Assumes inputs change without regard to i_mclk; only the last stage is read.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hp_params.svh"

module hp_sync #(
   parameter int W = `HP_SYNC_W
) (
   input  wire logic         i_mclk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_async,
   output var  logic [W-1:0] o_sync
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         logic meta_q;
         logic stab_q;
         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               meta_q <= 1'b0;
               stab_q <= 1'b0;
            end else begin
               meta_q <= i_async[g];
               stab_q <= meta_q;
            end
         end
         assign o_sync[g] = stab_q;
      end
   endgenerate
endmodule

`default_nettype wire

// >>> core/hp_fifo.sv
/*
 Small write FIFO with a registered output word and honest full and empty.
 Assumes one clock; the drain side may stall freely by holding ready low.
*/
`timescale 1ns/10ps
`default_nettype none
`include "hp_params.svh"

module hp_fifo #(
   parameter int WIDTH = `HP_FIFO_W,
   parameter int DEPTH = `HP_FIFO_DEPTH
) (
   input  wire logic i_mclk,
   input  wire logic i_rst,
   hp_fifo_if.fifo   port
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wptr_q, wptr_d, rptr_q, rptr_d;
   logic [PW:0]      cnt_q, cnt_d;
   logic             ov_q, ov_d;
   logic [WIDTH-1:0] od_q, od_d;
   logic             push, load;

   always_comb begin
      push      = port.in_valid && (cnt_q != (PW+1)'(DEPTH));
      load      = (cnt_q != '0) && (!ov_q || port.out_ready);
      wptr_d    = push ? PW'(wptr_q + 1'b1) : wptr_q;
      rptr_d    = load ? PW'(rptr_q + 1'b1) : rptr_q;
      cnt_d     = cnt_q + (PW+1)'(push) - (PW+1)'(load);
      ov_d      = load ? 1'b1 : (port.out_ready ? 1'b0 : ov_q);
      od_d      = load ? mem_q[rptr_q] : od_q;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
         ov_q   <= 1'b0;
         od_q   <= '0;
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q  <= cnt_d;
         ov_q   <= ov_d;
         od_q   <= od_d;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (push) begin
         mem_q[wptr_q] <= port.in_data;
      end
   end

   assign port.in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign port.out_valid = ov_q;
   assign port.out_data  = od_q;
endmodule

`default_nettype wire

// >>> core/host_port_pin_interface.sv
/*
 Pin front end of the 16-bit parallel host port and of the shared system data pins.
 Assumes configuration inputs are steady and synchronous; host pins are asynchronous;
 the internal register set answers a read pulse with data in the same cycle as the pulse.
*/
// Functional notes
// - With the port on, sixteen shared pins are a tri-state host data bus driven only on reads.
// - The four host address lines select the internal register of each access.
// - The port is selected when either chip select is active.
// - Single-strobe mode qualifies accesses by one strobe, the direction input picks the way.
// - Dual-strobe mode reads on the read strobe and writes on the write strobe.
// - The active level of every data strobe follows a programmed polarity.
// - Single-request mode shows all service needs on one combined request pin.
// - Each request pin is either driven or open drain, pulling only to its asserted level.
// - Double-request mode gives a transmit request pin saying the host may write.
// - Every request pin is asserted at a programmed active level.
// - Port off, the low 32 data pins are the upper word of the 64-bit bus; on, a 32-bit bus.
// - On the shared system pins the master drives writes and the slave drives reads.
// - With the port on, the width select picks an 8-bit or 16-bit host data width.
// - Double-request mode gives a receive request pin saying host data is ready to read.
`timescale 1ns/10ps
`default_nettype none
`include "hp_params.svh"

module host_port_pin_interface (
   input  wire logic                  i_mclk,
   input  wire logic                  i_rst,
   input  wire logic                  i_port_en,
   input  wire logic                  i_dual_strobe,
   input  wire logic                  i_strobe_pol,
   input  wire logic                  i_dual_req,
   input  wire logic                  i_req_pol,
   input  wire logic                  i_req_open_drain,
   input  wire logic                  i_host_width_sel,
   input  wire logic                  i_host_select_a,
   input  wire logic                  i_host_select_b,
   input  wire logic                  i_host_dir_in,
   input  wire logic                  i_host_read_strobe,
   input  wire logic                  i_host_write_strobe,
   input  wire logic                  i_host_single_strobe,
   input  wire logic [`HP_ADDR_W-1:0] i_host_reg_addr,
   input  wire logic [`HP_DATA_W-1:0] i_host_data_bus,
   output var  logic [`HP_DATA_W-1:0] o_host_data_bus,
   output var  logic [`HP_DATA_W-1:0] o_host_data_bus_oe,
   output var  logic                  o_host_service_req,
   output var  logic                  o_host_service_req_oe,
   output var  logic                  o_host_tx_req,
   output var  logic                  o_host_tx_req_oe,
   output var  logic                  o_host_rx_req,
   output var  logic                  o_host_rx_req_oe,
   input  wire logic                  i_rx_avail,
   input  wire logic                  i_tx_space,
   output var  logic                  o_reg_rd,
   output var  logic [`HP_ADDR_W-1:0] o_reg_rd_addr,
   input  wire logic [`HP_DATA_W-1:0] i_reg_rdata,
   output var  logic                  o_wr_valid,
   output var  logic [`HP_ADDR_W-1:0] o_wr_addr,
   output var  logic [`HP_DATA_W-1:0] o_wr_data,
   input  wire logic                  i_wr_ready,
   output var  logic                  o_host_8bit,
   input  wire logic                  i_sys_drive,
   input  wire logic [`HP_SYS_W-1:0]  i_sys_data,
   output var  logic [`HP_SYS_W-1:0]  o_sys_pins,
   output var  logic                  o_sys_pins_oe,
   output var  logic                  o_sys_bus64
);
   import hp_pkg::*;

   logic [`HP_SYNC_W-1:0] pin_raw;
   logic [`HP_SYNC_W-1:0] pin_s;
   logic                  sel, rd_act, wr_act, ds_act;
   logic                  tx_want, any_want;
   wr_word_t              wword;

   hp_fifo_if wfifo ();

   // Strobe and select synchroniser
   assign pin_raw[`HP_SYN_SEL_A] = i_host_select_a;
   assign pin_raw[`HP_SYN_SEL_B] = i_host_select_b;
   assign pin_raw[`HP_SYN_DIR]   = i_host_dir_in;
   assign pin_raw[`HP_SYN_RD]    = i_host_read_strobe;
   assign pin_raw[`HP_SYN_WR]    = i_host_write_strobe;
   assign pin_raw[`HP_SYN_DS]    = i_host_single_strobe;

   hp_sync #(
      .W (`HP_SYNC_W)
   ) u_sync (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_async (pin_raw),
      .o_sync  (pin_s)
   );

   hp_fifo #(
      .WIDTH (`HP_FIFO_W),
      .DEPTH (`HP_FIFO_DEPTH)
   ) u_fifo (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .port   (wfifo)
   );

   // Access decode
   always_comb begin
      sel    = i_port_en && (pin_s[`HP_SYN_SEL_A] || pin_s[`HP_SYN_SEL_B]);
      ds_act = (pin_s[`HP_SYN_DS] == i_strobe_pol);
      if (i_dual_strobe) begin
         rd_act = (pin_s[`HP_SYN_RD] == i_strobe_pol);
         wr_act = (pin_s[`HP_SYN_WR] == i_strobe_pol);
      end else begin
         rd_act = ds_act && pin_s[`HP_SYN_DIR];
         wr_act = ds_act && !pin_s[`HP_SYN_DIR];
      end
   end

   // Host access state
   acc_state_t            st_q, st_d;
   logic [`HP_ADDR_W-1:0] addr_q, addr_d;
   logic [`HP_DATA_W-1:0] hdo_q, hdo_d;
   logic [`HP_DATA_W-1:0] hoe_q, hoe_d;
   logic                  rd_q, rd_d;
   logic                  push_q, push_d;
   logic [`HP_DATA_W-1:0] wdat_q, wdat_d;
   logic                  w8_q, w8_d;

   always_comb begin
      st_d   = st_q;
      addr_d = addr_q;
      hdo_d  = hdo_q;
      hoe_d  = hoe_q;
      rd_d   = 1'b0;
      push_d = push_q;
      wdat_d = wdat_q;
      w8_d   = i_port_en ? i_host_width_sel : w8_q;
      unique case (st_q)
         ST_IDLE: begin
            hoe_d = `HP_ZERO16;
            if (sel && rd_act) begin
               addr_d = i_host_reg_addr;
               rd_d   = 1'b1;
               st_d   = ST_RD_FETCH;
            end else if (sel && wr_act) begin
               addr_d = i_host_reg_addr;
               wdat_d = w8_q ? {`HP_ZERO8, i_host_data_bus[`HP_BYTE_W-1:0]}
                             : i_host_data_bus;
               push_d = 1'b1;
               st_d   = ST_WR_PUSH;
            end
         end
         ST_RD_FETCH: begin
            hdo_d = w8_q ? {`HP_ZERO8, i_reg_rdata[`HP_BYTE_W-1:0]} : i_reg_rdata;
            hoe_d = w8_q ? `HP_OE_BYTE : `HP_OE_ALL;
            st_d  = ST_RD_DRIVE;
            if (!(sel && rd_act)) begin
               hoe_d = `HP_ZERO16;
               st_d  = ST_IDLE;
            end
         end
         ST_RD_DRIVE: begin
            if (!(sel && rd_act)) begin
               hoe_d = `HP_ZERO16;
               st_d  = ST_IDLE;
            end
         end
         ST_WR_PUSH: begin
            if (wfifo.in_ready) begin
               push_d = 1'b0;
               st_d   = ST_WAIT_END;
            end
         end
         ST_WAIT_END: begin
            if (!(sel && (rd_act || wr_act))) begin
               st_d = ST_IDLE;
            end
         end
      endcase
      if (!i_port_en && st_q != ST_WR_PUSH) begin
         hoe_d = `HP_ZERO16;
         st_d  = ST_IDLE;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         st_q   <= ST_IDLE;
         addr_q <= `HP_ZERO4;
         hdo_q  <= `HP_ZERO16;
         hoe_q  <= `HP_ZERO16;
         rd_q   <= 1'b0;
         push_q <= 1'b0;
         wdat_q <= `HP_ZERO16;
         w8_q   <= 1'b0;
      end else begin
         st_q   <= st_d;
         addr_q <= addr_d;
         hdo_q  <= hdo_d;
         hoe_q  <= hoe_d;
         rd_q   <= rd_d;
         push_q <= push_d;
         wdat_q <= wdat_d;
         w8_q   <= w8_d;
      end
   end

   // Write path into the FIFO
   always_comb begin
      wword.addr       = addr_q;
      wword.data       = wdat_q;
      wfifo.in_valid   = push_q;
      wfifo.in_data    = wword;
      wfifo.out_ready  = i_wr_ready;
   end

   // Request pins
   logic srv_q, srv_d, srv_oe_q, srv_oe_d;
   logic tx_q, tx_d, tx_oe_q, tx_oe_d;
   logic rx_q, rx_d, rx_oe_q, rx_oe_d;

   always_comb begin
      tx_want  = i_tx_space && wfifo.in_ready;
      any_want = i_rx_avail || tx_want;
      srv_d    = i_req_open_drain ? i_req_pol : (any_want ? i_req_pol : !i_req_pol);
      srv_oe_d = i_port_en && !i_dual_req && (!i_req_open_drain || any_want);
      tx_d     = i_req_open_drain ? i_req_pol : (tx_want ? i_req_pol : !i_req_pol);
      tx_oe_d  = i_port_en && i_dual_req && (!i_req_open_drain || tx_want);
      rx_d     = i_req_open_drain ? i_req_pol : (i_rx_avail ? i_req_pol : !i_req_pol);
      rx_oe_d  = i_port_en && i_dual_req && (!i_req_open_drain || i_rx_avail);
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         srv_q    <= 1'b0;
         srv_oe_q <= 1'b0;
         tx_q     <= 1'b0;
         tx_oe_q  <= 1'b0;
         rx_q     <= 1'b0;
         rx_oe_q  <= 1'b0;
      end else begin
         srv_q    <= srv_d;
         srv_oe_q <= srv_oe_d;
         tx_q     <= tx_d;
         tx_oe_q  <= tx_oe_d;
         rx_q     <= rx_d;
         rx_oe_q  <= rx_oe_d;
      end
   end

   // Shared system data pins
   logic [`HP_SYS_W-1:0] sys_q, sys_d;
   logic                 sys_oe_q, sys_oe_d;
   logic                 b64_q, b64_d;

   always_comb begin
      sys_d    = i_sys_drive ? i_sys_data : `HP_ZERO32;
      sys_oe_d = i_sys_drive;
      b64_d    = !i_port_en;
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sys_q    <= `HP_ZERO32;
         sys_oe_q <= 1'b0;
         b64_q    <= 1'b1;
      end else begin
         sys_q    <= sys_d;
         sys_oe_q <= sys_oe_d;
         b64_q    <= b64_d;
      end
   end

   assign o_host_data_bus       = hdo_q;
   assign o_host_data_bus_oe    = hoe_q;
   assign o_host_service_req    = srv_q;
   assign o_host_service_req_oe = srv_oe_q;
   assign o_host_tx_req         = tx_q;
   assign o_host_tx_req_oe      = tx_oe_q;
   assign o_host_rx_req         = rx_q;
   assign o_host_rx_req_oe      = rx_oe_q;
   assign o_reg_rd              = rd_q;
   assign o_reg_rd_addr         = addr_q;
   assign o_wr_valid            = wfifo.out_valid;
   assign o_wr_addr             = wfifo.out_data[`HP_FIFO_W-1:`HP_DATA_W];
   assign o_wr_data             = wfifo.out_data[`HP_DATA_W-1:0];
   assign o_host_8bit           = w8_q;
   assign o_sys_pins            = sys_q;
   assign o_sys_pins_oe         = sys_oe_q;
   assign o_sys_bus64           = b64_q;
endmodule

`default_nettype wire

// >>> bench/host_port_checker.sv
/*
 Port checker for the host port front end; sees only the top module's ports.
 Assumes one clock and that inputs change away from the rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module host_port_checker (
   input wire logic        i_mclk,
   input wire logic        i_rst,
   input wire logic        i_port_en,
   input wire logic        i_dual_req,
   input wire logic        i_req_pol,
   input wire logic        i_req_open_drain,
   input wire logic        i_host_select_a,
   input wire logic        i_host_select_b,
   input wire logic        i_rx_avail,
   input wire logic [15:0] i_reg_rdata,
   input wire logic        i_sys_drive,
   input wire logic [31:0] i_sys_data,
   input wire logic [15:0] o_host_data_bus,
   input wire logic [15:0] o_host_data_bus_oe,
   input wire logic        o_host_service_req,
   input wire logic        o_host_service_req_oe,
   input wire logic        o_host_rx_req,
   input wire logic        o_host_rx_req_oe,
   input wire logic        o_reg_rd,
   input wire logic        o_host_8bit,
   input wire logic [31:0] o_sys_pins,
   input wire logic        o_sys_pins_oe,
   input wire logic        o_sys_bus64
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   sequence s_fetch;
      o_reg_rd;
   endsequence
   sequence s_drive_start;
      $rose(o_host_data_bus_oe != 16'h0000);
   endsequence

   property p_bus_idle_off;
      !i_port_en [*3] |-> o_host_data_bus_oe == 16'h0000;
   endproperty
   property p_oe_width;
      o_host_data_bus_oe != 16'h0000 |->
         o_host_data_bus_oe == (o_host_8bit ? 16'h00ff : 16'hffff)
         && (o_host_data_bus & ~o_host_data_bus_oe) == 16'h0000;
   endproperty
   property p_drive_after_fetch;
      s_drive_start |-> $past(o_reg_rd)
         && ((o_host_data_bus ^ $past(i_reg_rdata)) & o_host_data_bus_oe) == 16'h0000;
   endproperty
   property p_sel_before_fetch;
      s_fetch |-> $past(i_host_select_a | i_host_select_b, 2)
         && $past(i_host_select_a | i_host_select_b, 3) && $past(i_port_en);
   endproperty
   property p_single_req;
      !$past(i_rst) && $past(i_port_en && !i_dual_req && i_rx_avail) |->
         o_host_service_req_oe && o_host_service_req == $past(i_req_pol);
   endproperty
   property p_rx_req;
      !$past(i_rst) && $past(i_port_en && i_dual_req) |->
         o_host_rx_req_oe == $past(i_rx_avail || !i_req_open_drain)
         && o_host_rx_req == $past(i_req_pol ^ (!i_rx_avail && !i_req_open_drain));
   endproperty
   property p_bus_mode;
      !$past(i_rst) |-> o_sys_bus64 == !$past(i_port_en);
   endproperty
   property p_sys_pins;
      !$past(i_rst) && $past(i_sys_drive) |-> o_sys_pins_oe && o_sys_pins == $past(i_sys_data);
   endproperty

   a_bus_idle_off: assert property (p_bus_idle_off)
      else $error("host data bus driven while port disabled");
   a_oe_width: assert property (p_oe_width)
      else $error("host data enable does not match width");
   a_drive_after_fetch: assert property (p_drive_after_fetch)
      else $error("host read drive not from fetched data");
   a_sel_before_fetch: assert property (p_sel_before_fetch)
      else $error("register read without synchronised select");
   a_single_req: assert property (p_single_req)
      else $error("combined request pin wrong");
   a_rx_req: assert property (p_rx_req)
      else $error("receive request pin wrong");
   a_bus_mode: assert property (p_bus_mode)
      else $error("system bus width flag wrong");
   a_sys_pins: assert property (p_sys_pins)
      else $error("shared system pins wrong");
endmodule

bind host_port_pin_interface host_port_checker host_port_checker_inst (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_port_en(i_port_en), .i_dual_req(i_dual_req),
   .i_req_pol(i_req_pol), .i_req_open_drain(i_req_open_drain),
   .i_host_select_a(i_host_select_a), .i_host_select_b(i_host_select_b),
   .i_rx_avail(i_rx_avail), .i_reg_rdata(i_reg_rdata), .i_sys_drive(i_sys_drive),
   .i_sys_data(i_sys_data), .o_host_data_bus(o_host_data_bus),
   .o_host_data_bus_oe(o_host_data_bus_oe), .o_host_service_req(o_host_service_req),
   .o_host_service_req_oe(o_host_service_req_oe), .o_host_rx_req(o_host_rx_req),
   .o_host_rx_req_oe(o_host_rx_req_oe), .o_reg_rd(o_reg_rd), .o_host_8bit(o_host_8bit),
   .o_sys_pins(o_sys_pins), .o_sys_pins_oe(o_sys_pins_oe), .o_sys_bus64(o_sys_bus64));

`default_nettype wire

// >>> bench/host_model.sv
/*
 Host processor model: selects, strobes, address and data of the host port.
 Assumes the bench resolves the shared data pins and feeds them back on i_bus.
*/
`timescale 1ns/10ps
`default_nettype none

module host_model (
   input  wire logic        i_mclk,
   input  wire logic        i_pol,
   input  wire logic [15:0] i_bus,
   output var  logic        o_sel_a,
   output var  logic        o_sel_b,
   output var  logic        o_dir,
   output var  logic        o_rd,
   output var  logic        o_wr,
   output var  logic        o_ds,
   output var  logic [3:0]  o_addr,
   output var  logic [15:0] o_data
);
   logic act_rd = 1'b0;
   logic act_wr = 1'b0;
   logic act_ds = 1'b0;

   // Strobes rest at the inactive level
   assign o_rd = act_rd ~^ i_pol;
   assign o_wr = act_wr ~^ i_pol;
   assign o_ds = act_ds ~^ i_pol;

   initial begin
      {o_sel_a, o_sel_b, o_dir, o_addr, o_data} = 23'h0;
   end

   task automatic access(input logic rd, input logic dual, input logic use_b,
                         input logic [3:0] a, input logic [15:0] d,
                         output logic [15:0] q);
      @(negedge i_mclk);
      o_addr = a;
      o_dir = rd;
      o_data = rd ? ~o_data : d;
      o_sel_a = !use_b;
      o_sel_b = use_b;
      @(negedge i_mclk);
      act_ds = !dual;
      act_rd = dual && rd;
      act_wr = dual && !rd;
      repeat (8) @(negedge i_mclk);
      q = i_bus;
      {act_rd, act_wr, act_ds} = 3'h0;
      @(negedge i_mclk);
      {o_sel_a, o_sel_b} = 2'h0;
      // Released line shows the inverse of the last value
      o_data = ~o_data;
      repeat (4) @(negedge i_mclk);
   endtask
endmodule

`default_nettype wire

// >>> bench/host_port_pin_interface_tb.sv
/*
 Self-checking bench for the host port front end.
 Assumes host_model as the host and a register set that answers in the same cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module host_port_pin_interface_tb;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        en = 1'b1;
   logic        dual_s = 1'b0;
   logic        spol = 1'b1;
   logic        dual_r = 1'b1;
   logic        rpol = 1'b1;
   logic        od = 1'b0;
   logic        wsel = 1'b0;
   logic        rx_av = 1'b0;
   logic        tx_sp = 1'b1;
   logic        wr_rdy = 1'b1;
   logic        sys_drv = 1'b0;
   logic [31:0] sys_d = 32'h0000_0000;
   logic        sa, sb, dir, hr, hw, hs, srq, srq_oe, trq, trq_oe, rrq, rrq_oe;
   logic        rd_p, wr_v, h8, sys_oe, b64;
   logic [3:0]  ha, rd_a, wr_a;
   logic [15:0] hdat, hd_o, hd_oe, rdata, wr_d, hbus, q;
   logic [31:0] sys_p;
   logic [19:0] got_q[$];
   int          bad_count = 0;
   int          checks_done = 0;
   int          rd_count = 0;

   always #4 mclk = ~mclk;
   assign hbus = (hd_oe & hd_o) | (~hd_oe & hdat);
   assign rdata = {rd_a, 8'hc3, ~rd_a};

   always @(posedge mclk) begin
      if (rd_p) rd_count++;
      if (wr_v && wr_rdy) got_q.push_back({wr_a, wr_d});
   end

   host_port_pin_interface host_port_pin_interface_inst (
      .i_mclk(mclk), .i_rst(rst), .i_port_en(en), .i_dual_strobe(dual_s),
      .i_strobe_pol(spol), .i_dual_req(dual_r), .i_req_pol(rpol), .i_req_open_drain(od),
      .i_host_width_sel(wsel), .i_host_select_a(sa), .i_host_select_b(sb),
      .i_host_dir_in(dir), .i_host_read_strobe(hr), .i_host_write_strobe(hw),
      .i_host_single_strobe(hs), .i_host_reg_addr(ha), .i_host_data_bus(hbus),
      .o_host_data_bus(hd_o), .o_host_data_bus_oe(hd_oe), .o_host_service_req(srq),
      .o_host_service_req_oe(srq_oe), .o_host_tx_req(trq), .o_host_tx_req_oe(trq_oe),
      .o_host_rx_req(rrq), .o_host_rx_req_oe(rrq_oe), .i_rx_avail(rx_av),
      .i_tx_space(tx_sp), .o_reg_rd(rd_p), .o_reg_rd_addr(rd_a), .i_reg_rdata(rdata),
      .o_wr_valid(wr_v), .o_wr_addr(wr_a), .o_wr_data(wr_d), .i_wr_ready(wr_rdy),
      .o_host_8bit(h8), .i_sys_drive(sys_drv), .i_sys_data(sys_d), .o_sys_pins(sys_p),
      .o_sys_pins_oe(sys_oe), .o_sys_bus64(b64));

   host_model host_model_inst (
      .i_mclk(mclk), .i_pol(spol), .i_bus(hbus), .o_sel_a(sa), .o_sel_b(sb), .o_dir(dir),
      .o_rd(hr), .o_wr(hw), .o_ds(hs), .o_addr(ha), .o_data(hdat));

   task automatic final_report;
      if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic pop_chk(input logic [19:0] exp);
      int n;
      n = 0;
      while (got_q.size() == 0 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      if (got_q.size() == 0) chk(32'hx, {12'h0, exp});
      else chk({12'h0, got_q.pop_front()}, {12'h0, exp});
   endtask

   task automatic acc(input logic rd, input logic use_b, input logic [3:0] a,
                      input logic [15:0] d);
      host_model_inst.access(rd, dual_s, use_b, a, d, q);
   endtask

   initial begin
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      // Both strobe styles at both polarities
      for (int m = 0; m < 4; m++) begin
         dual_s = m[0];
         spol = m[1];
         repeat (3) @(negedge mclk);
         acc(1'b0, m[0], 4'(m + 3), 16'h5a00 + 16'(m));
         pop_chk({4'(m + 3), 16'h5a00 + 16'(m)});
         acc(1'b1, m[1], 4'(m + 9), 16'h0000);
         chk({16'h0, q}, {16'h0, 4'(m + 9), 8'hc3, ~4'(m + 9)});
      end
      // Narrow width
      wsel = 1'b1;
      acc(1'b0, 1'b0, 4'h1, 16'hbeef);
      pop_chk({4'h1, 16'h00ef});
      acc(1'b1, 1'b1, 4'h2, 16'h0000);
      chk({24'h0, q[7:0]}, 32'h0000_003d);
      chk_bit(h8, 1'b1);
      wsel = 1'b0;
      // Port disabled
      en = 1'b0;
      rd_count = 0;
      acc(1'b1, 1'b0, 4'h5, 16'h0000);
      acc(1'b0, 1'b1, 4'h6, 16'h1111);
      chk(rd_count, 0);
      chk(got_q.size(), 0);
      chk_bit(b64, 1'b1);
      sys_drv = 1'b1;
      sys_d = 32'hcafe_0123;
      repeat (2) @(negedge mclk);
      chk(sys_p, 32'hcafe_0123);
      chk_bit(sys_oe, 1'b1);
      sys_drv = 1'b0;
      en = 1'b1;
      repeat (2) @(negedge mclk);
      chk_bit(b64, 1'b0);
      // Fill the write path with the drain stalled, then drain
      wr_rdy = 1'b0;
      for (int k = 0; k < 6; k++) acc(1'b0, 1'b0, 4'(k), 16'h0c00 + 16'(k));
      chk_bit(trq, 1'b0);
      chk_bit(wr_v, 1'b1);
      for (int k = 0; k < 24; k++) begin
         @(negedge mclk);
         wr_rdy = k[0];
      end
      wr_rdy = 1'b1;
      for (int k = 0; k < 6; k++) pop_chk({4'(k), 16'h0c00 + 16'(k)});
      chk_bit(trq, 1'b1);
      // Request pins in every mode, drive style and polarity
      tx_sp = 1'b0;
      for (int k = 0; k < 16; k++) begin
         {rx_av, dual_r, od, rpol} = 4'(k);
         repeat (2) @(negedge mclk);
         chk_bit(dual_r ? rrq_oe : srq_oe, rx_av || !od);
         chk_bit(dual_r ? rrq : srq, rpol ^ (!rx_av && !od));
         if (dual_r && !od) chk_bit(trq, !rpol);
         chk_bit(trq_oe, dual_r && !od);
         chk_bit(dual_r ? srq_oe : rrq_oe, 1'b0);
      end
      // Combined pin also carries the transmit need
      {rx_av, dual_r, od, rpol} = 4'h3;
      tx_sp = 1'b1;
      repeat (2) @(negedge mclk);
      chk_bit(srq_oe, 1'b1);
      chk_bit(srq, 1'b1);
      final_report();
   end

   initial begin
      #100000;
      bad_count++;
      final_report();
   end
endmodule

`default_nettype wire
